// *** record_retransmit_engine.v ***
`timescale 1ns/100ps
`include "retx_regs.vh"
module record_retransmit_engine #(
  parameter NPORT = 4, // Number of network ports
  parameter [31:0] ID_VALUE = 32'h0000_0a5a // Arbitrary identification value
) (
  input wire ref_clk, // 10 MHz clock
  input wire rstn, // Async reset, active low
  input wire ce, // Clock enable, freezes all state
  input wire [3:0] reg_addr, // Register word index
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata_ff, // Read data, cycle after strobe
  input wire rec_valid, // Record word valid
  input wire [63:0] rec_data, // Record word
  input wire rec_last, // Last word of record
  output wire rec_ready, // Engine takes word
  input wire capture_active, // Receive path capturing
  output reg [NPORT-1:0] tx_valid_ff, // Byte valid per port
  output reg [7:0] tx_data_ff, // Byte to the selected port
  output reg tx_last_ff, // Last byte of frame
  input wire [NPORT-1:0] tx_ready // Port accepts byte
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [2:0] S_HDR = 3'h0;
  localparam [2:0] S_LOAD = 3'h1;
  localparam [2:0] S_BYTE = 3'h2;
  localparam [2:0] S_CRC = 3'h3;
  localparam [2:0] S_DROP = 3'h4;

  reg [2:0] state_ff, nxt_state;
  reg [31:0] ctrl_ff;
  reg [15:0] tx_mem_ff;
  reg [31:0] sent_cnt_ff, drop_cnt_ff;
  reg [1:0] port_ff, nxt_port;
  reg [15:0] remain_ff, nxt_remain; // Payload bytes still to send
  reg [15:0] words_ff, nxt_words; // Record bytes still to take, counted down eight per word
  reg [63:0] shift_ff, nxt_shift;
  reg [2:0] lane_ff, nxt_lane;
  reg [1:0] crc_idx_ff, nxt_crc_idx;
  reg slot_ff, nxt_slot;
  reg load_wait_ff;
  reg load_hold_ff; // Store read data ready to load
  reg strip_lat_ff, txcrc_lat_ff, nxt_strip_lat, nxt_txcrc_lat;

  wire strip_opt = ctrl_ff[`CTRL_STRIP_BIT];
  wire txcrc_opt = ctrl_ff[`CTRL_TXCRC_BIT];
  wire droperr_opt = ctrl_ff[`CTRL_DROPERR_BIT];
  wire eng_en = ctrl_ff[`CTRL_ENABLE_BIT];
  wire [31:0] crc_val;
  wire [63:0] stage_q;

  // Header decode is used in more than one place
  function [15:0] hdr_len;
    input [63:0] h;
    begin
      hdr_len = h[`HDR_LEN_MSB:`HDR_LEN_LSB];
    end
  endfunction

  function [1:0] hdr_port;
    input [63:0] h;
    begin
      hdr_port = h[`HDR_PORT_MSB:`HDR_PORT_LSB];
    end
  endfunction

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Split register is software-owned; hardware never locks it, host keeps it stable
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= `CTRL_RESET_VAL;
      tx_mem_ff <= `TX_MEM_RESET_MB;
      reg_rdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (reg_wr) begin
        if (reg_addr == `REG_CTRL) begin
          ctrl_ff <= {28'h000_0000, reg_wdata[3:0]};
        end
        if (reg_addr == `REG_TX_MEM) begin
          tx_mem_ff <= reg_wdata[15:0];
        end
      end
      // Status shows the framer state for bring-up, not for flow control
      if (reg_rd) begin
        case (reg_addr)
          `REG_CTRL: reg_rdata_ff <= ctrl_ff;
          `REG_STATUS: reg_rdata_ff <= {24'h00_0000, capture_active, 4'h0, state_ff};
          `REG_TX_MEM: reg_rdata_ff <= {16'h0000, tx_mem_ff};
          `REG_SENT_CNT: reg_rdata_ff <= sent_cnt_ff;
          `REG_DROP_CNT: reg_rdata_ff <= drop_cnt_ff;
          `REG_ID: reg_rdata_ff <= ID_VALUE;
          default: reg_rdata_ff <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata_ff <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Record intake and framing
  // ----------------------------------------
  // Capture path is a separate block; nothing here stalls it.
  // Every take goes through rec_ready, so clearing enable or ce
  // mid-record can never consume a word the host still holds
  wire rec_take = rec_valid && rec_ready;
  wire hdr_take = (state_ff == S_HDR) && rec_take;
  wire word_take = (state_ff == S_LOAD) && rec_take;
  wire drop_take = (state_ff == S_DROP) && rec_take;
  assign rec_ready = ce && eng_en && ((state_ff == S_HDR) || (state_ff == S_DROP) ||
                     ((state_ff == S_LOAD) && !load_wait_ff && !load_hold_ff));

  // One-hot port decode; a port number beyond NPORT selects
  // nothing, so such a record stalls instead of going astray
  wire [NPORT-1:0] port_sel;
  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port_sel
      localparam [31:0] PNUM = gi;
      assign port_sel[gi] = (port_ff == PNUM[1:0]);
    end
  endgenerate

  // Only the one selected port is ever driven.
  wire port_rdy = |(tx_ready & port_sel);
  wire byte_go = (state_ff == S_BYTE) && port_rdy;
  wire crc_go = (state_ff == S_CRC) && port_rdy;

  word_stage #(.DW(64)) u_stage (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .wr_en(word_take),
    .wr_addr(slot_ff),
    .wr_data(rec_data),
    .rd_addr(slot_ff),
    .rd_data_ff(stage_q)
  );

  crc32_unit u_crc (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .init(hdr_take),
    .in_valid(byte_go),
    .in_byte(shift_ff[7:0]),
    .crc_out(crc_val)
  );

  // Next-state logic for the framer
  always @* begin
    nxt_state = state_ff;
    nxt_port = port_ff;
    nxt_remain = remain_ff;
    nxt_words = words_ff;
    nxt_shift = shift_ff;
    nxt_lane = lane_ff;
    nxt_crc_idx = crc_idx_ff;
    nxt_slot = slot_ff;
    nxt_strip_lat = strip_lat_ff;
    nxt_txcrc_lat = txcrc_lat_ff;
    case (state_ff)
      S_HDR: begin
        if (hdr_take) begin
          nxt_port = hdr_port(rec_data);
          nxt_words = hdr_len(rec_data) - `WORD_BYTES;
          nxt_strip_lat = strip_opt;
          nxt_txcrc_lat = txcrc_opt;
          // Frame shortened by four bytes when stripping.
          nxt_remain = hdr_len(rec_data) - `WORD_BYTES - (strip_opt ? `CRC_BYTES : 16'h0000);
          // Header-only record: nothing to send
          if (rec_last) begin
            nxt_state = S_HDR;
          end else if (droperr_opt && rec_data[`HDR_RXERR_BIT]) begin
            nxt_state = S_DROP;
          end else begin
            nxt_state = S_LOAD;
          end
        end
      end
      S_DROP: begin
        // Swallow the rest of the record, CRC tail included
        if (drop_take && rec_last) begin
          nxt_state = S_HDR;
        end
      end
      S_LOAD: begin
        // Two cycles after a take: one writes the store, one lets
        // its registered read present the new word
        if (load_hold_ff) begin
          nxt_shift = stage_q;
          nxt_lane = 3'h0;
          nxt_state = S_BYTE;
        end else if (word_take) begin
          nxt_words = words_ff - `WORD_BYTES;
        end
      end
      S_BYTE: begin
        // A stalled port simply holds the byte; nothing is skipped
        if (byte_go) begin
          nxt_shift = {8'h00, shift_ff[63:8]};
          nxt_lane = lane_ff + 3'h1;
          nxt_remain = remain_ff - 16'h0001;
          if (remain_ff == 16'h0001) begin
            // Trailing supplied CRC bytes, if any, are simply not sent.
            nxt_crc_idx = 2'h0;
            nxt_state = txcrc_lat_ff ? S_CRC : (words_ff == 16'h0000 ? S_HDR : S_DROP);
          end else if (lane_ff == 3'h7) begin
            nxt_slot = ~slot_ff;
            nxt_state = S_LOAD;
          end
        end
      end
      S_CRC: begin
        // Four fresh CRC bytes, low byte first
        if (crc_go) begin
          nxt_crc_idx = crc_idx_ff + 2'h1;
          if (crc_idx_ff == 2'h3) begin
            nxt_state = (words_ff == 16'h0000) ? S_HDR : S_DROP;
          end
        end
      end
      default: nxt_state = S_HDR;
    endcase
  end

  // Byte picked from the fresh CRC, low byte first
  wire [7:0] crc_byte = crc_val[{crc_idx_ff, 3'h0} +: 8];
  wire frame_end = (byte_go && remain_ff == 16'h0001 && !txcrc_lat_ff) ||
                   (crc_go && crc_idx_ff == 2'h3);

  // State and output registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= S_HDR;
      port_ff <= 2'h0;
      remain_ff <= 16'h0000;
      words_ff <= 16'h0000;
      shift_ff <= 64'h0000_0000_0000_0000;
      lane_ff <= 3'h0;
      crc_idx_ff <= 2'h0;
      slot_ff <= 1'b0;
      load_wait_ff <= 1'b0;
      load_hold_ff <= 1'b0;
      strip_lat_ff <= 1'b0;
      txcrc_lat_ff <= 1'b0;
      tx_valid_ff <= {NPORT{1'b0}};
      tx_data_ff <= 8'h00;
      tx_last_ff <= 1'b0;
      sent_cnt_ff <= 32'h0000_0000;
      drop_cnt_ff <= 32'h0000_0000;
    end else if (ce) begin
      state_ff <= nxt_state;
      port_ff <= nxt_port;
      remain_ff <= nxt_remain;
      words_ff <= nxt_words;
      shift_ff <= nxt_shift;
      lane_ff <= nxt_lane;
      crc_idx_ff <= nxt_crc_idx;
      slot_ff <= nxt_slot;
      strip_lat_ff <= nxt_strip_lat;
      txcrc_lat_ff <= nxt_txcrc_lat;
      // Two cycles for the store write and its registered read
      load_wait_ff <= word_take;
      load_hold_ff <= load_wait_ff;
      // Bytes go out whenever the port is ready, no pacing.
      tx_valid_ff <= {NPORT{1'b0}};
      tx_last_ff <= 1'b0;
      if (byte_go || crc_go) begin
        tx_valid_ff <= port_sel;
        tx_data_ff <= byte_go ? shift_ff[7:0] : crc_byte;
        tx_last_ff <= frame_end;
      end
      if (frame_end) begin
        sent_cnt_ff <= sent_cnt_ff + 32'h0000_0001;
      end
      if (hdr_take && droperr_opt && rec_data[`HDR_RXERR_BIT]) begin
        drop_cnt_ff <= drop_cnt_ff + 32'h0000_0001;
      end
    end
  end
endmodule // record_retransmit_engine

// *** retx_regs.vh ***
`ifndef RETX_REGS_VH
`define RETX_REGS_VH
// ----------------------------------------
// Register offsets (word index on plain port)
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_TX_MEM 4'h2
`define REG_SENT_CNT 4'h3
`define REG_DROP_CNT 4'h4
`define REG_ID 4'h5
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_STRIP_BIT 0
`define CTRL_TXCRC_BIT 1
`define CTRL_DROPERR_BIT 2
`define CTRL_ENABLE_BIT 3
`define CTRL_RESET_VAL 32'h0000_0000
// Transmit share of buffer memory in MB after reset
`define TX_MEM_RESET_MB 16'h0010
// ----------------------------------------
// Record header layout (first 64-bit word)
// ----------------------------------------
`define HDR_LEN_LSB 0
`define HDR_LEN_MSB 15
`define HDR_PORT_LSB 16
`define HDR_PORT_MSB 17
`define HDR_RXERR_BIT 24
`define HDR_TYPE_LSB 32
`define HDR_TYPE_MSB 39
`define CRC_BYTES 16'h0004
`define WORD_BYTES 16'h0008
`define CRC_POLY 32'hedb8_8320
`define CRC_INIT 32'hffff_ffff
`endif

// *** crc32_unit.v ***
`timescale 1ns/100ps
// ----------------------------------------
// Byte-wise Ethernet CRC32 accumulator
// ----------------------------------------
`include "retx_regs.vh"
module crc32_unit (
  input wire ref_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire ce, // Clock enable
  input wire init, // Restart CRC
  input wire in_valid, // Byte valid
  input wire [7:0] in_byte, // Data byte
  output wire [31:0] crc_out // Final CRC, already inverted
);
  reg [31:0] crc_ff;

  function [31:0] crc_step;
    input [31:0] c;
    input [7:0] b;
    integer i;
    reg [31:0] t;
    begin
      t = c ^ {24'h00_0000, b};
      for (i = 0; i < 8; i = i + 1) begin
        t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  // Accumulate; init wins so each frame starts clean
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crc_ff <= `CRC_INIT;
    end else if (ce) begin
      if (init) begin
        crc_ff <= `CRC_INIT;
      end else if (in_valid) begin
        crc_ff <= crc_step(crc_ff, in_byte);
      end
    end
  end

  assign crc_out = ~crc_ff;
endmodule // crc32_unit

// *** word_stage.v ***
`timescale 1ns/100ps
// ----------------------------------------
// Two-entry record word store, registered read
// ----------------------------------------
module word_stage #(
  parameter DW = 64 // Word width
) (
  input wire ref_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire ce, // Clock enable
  input wire wr_en, // Write strobe
  input wire wr_addr, // Write slot
  input wire [DW-1:0] wr_data, // Write data
  input wire rd_addr, // Read slot
  output reg [DW-1:0] rd_data_ff // Registered read data
);
  reg [DW-1:0] mem_ff [0:1];

  // Small store; read data always registered
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ff[0] <= {DW{1'b0}};
      mem_ff[1] <= {DW{1'b0}};
      rd_data_ff <= {DW{1'b0}};
    end else if (ce) begin
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
      rd_data_ff <= mem_ff[rd_addr];
    end
  end
endmodule // word_stage

// *** record_retransmit_checks_properties.sv ***
`timescale 1ns/100ps
`include "retx_regs.vh"
// ------
// Engine port checks
// ------
module record_retransmit_checks #(
  parameter NPORT = 4,
  parameter [31:0] ID_VALUE = 32'h0
) (
  input wire ref_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire ce, // Clock enable
  input wire [3:0] reg_addr, // Register index
  input wire [31:0] reg_wdata, // Write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  input wire [31:0] reg_rdata_ff, // Read data
  input wire rec_valid, // Word valid
  input wire rec_ready, // Word taken
  input wire capture_active, // Receive running
  input wire [NPORT-1:0] tx_valid_ff, // Byte valid per port
  input wire tx_last_ff // Last byte
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  reg en_ff;
  reg seen_ff;
  reg txw_ff;
  // Track enable, first taken word and any split rewrite
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      en_ff <= 1'b0;
      seen_ff <= 1'b0;
      txw_ff <= 1'b0;
    end else if (ce) begin
      if (reg_wr && reg_addr == `REG_CTRL) en_ff <= reg_wdata[`CTRL_ENABLE_BIT];
      if (reg_wr && reg_addr == `REG_TX_MEM) txw_ff <= 1'b1;
      if (rec_valid && rec_ready) seen_ff <= 1'b1;
    end
  end
  sequence rd_of(logic [3:0] a);
    ce && reg_rd && reg_addr == a;
  endsequence
  a_rdata_idle: assert property ($past(ce) && !$past(reg_rd) |-> reg_rdata_ff == 32'h0)
    else $error("read data outside answer cycle");
  a_id_value: assert property (rd_of(`REG_ID) |=> reg_rdata_ff == ID_VALUE)
    else $error("identification read wrong");
  a_unmapped_zero: assert property (ce && reg_rd && reg_addr > `REG_ID |=> reg_rdata_ff == 32'h0)
    else $error("unmapped read not zero");
  a_split_reset: assert property (rd_of(`REG_TX_MEM) ##0 !txw_ff |=> reg_rdata_ff == {16'h0, `TX_MEM_RESET_MB})
    else $error("transmit share not default");
  a_capture_shown: assert property (rd_of(`REG_STATUS) |=> reg_rdata_ff[7] == $past(capture_active))
    else $error("capture flag not shown");
  a_one_port: assert property ($onehot0(tx_valid_ff))
    else $error("two ports fed at once");
  a_last_in_byte: assert property (tx_last_ff |-> |tx_valid_ff)
    else $error("frame end without byte");
  a_no_unasked: assert property (|tx_valid_ff |-> seen_ff)
    else $error("byte sent with no record");
  a_idle_gated: assert property (!en_ff |-> !rec_ready)
    else $error("word taken while disabled");
endmodule // record_retransmit_checks

bind record_retransmit_engine record_retransmit_checks #(.NPORT(NPORT), .ID_VALUE(ID_VALUE)) i_record_retransmit_checks (
  .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .rec_valid(rec_valid), .rec_ready(rec_ready),
  .capture_active(capture_active), .tx_valid_ff(tx_valid_ff), .tx_last_ff(tx_last_ff));

// *** record_source.sv ***
`timescale 1ns/100ps
// ------
// Host side record feeder
// ------
module record_source (
  input wire ref_clk, // Clock
  input wire rstn, // Async reset, active low
  input wire rec_ready, // Engine takes word
  output reg rec_valid, // Word valid
  output reg [63:0] rec_data, // Record word
  output reg rec_last // Last word of record
);
  logic [64:0] q[$];
  bit slow = 1'b0;
  bit idle_b;
  // Whole records of 64-bit words, link type as configured
  task push(input logic [63:0] w, input logic l);
    q.push_back({l, w});
  endtask
  // Hold a word until taken; slow mode idles after each, as a late commit would
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rec_valid <= 1'b0;
      rec_data <= 64'h0;
      rec_last <= 1'b0;
    end else if (!rec_valid || rec_ready) begin
      idle_b = 1'b0;
      if (rec_valid) begin
        void'(q.pop_front());
        idle_b = slow;
      end
      if (q.size() != 0 && !idle_b) begin
        rec_valid <= 1'b1;
        {rec_last, rec_data} <= q[0];
      end else begin
        // Released lines flip so a stale word is never mistaken for data
        rec_valid <= 1'b0;
        rec_data <= ~rec_data;
        rec_last <= ~rec_last;
      end
    end
  end
endmodule // record_source

// *** testbench.sv ***
`timescale 1ns/100ps
`include "retx_regs.vh"
module testbench;
  localparam [31:0] ID_VAL = 32'h0000_3c69; // Arbitrary identification value
  localparam [7:0] LINK_TYPE = 8'h02; // Configured link type
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic capture_active = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [3:0] tx_ready = 4'hf; // All ports up except in the stall test
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata_ff, rv;
  logic rec_valid, rec_last, rec_ready, tx_last_ff;
  logic [63:0] rec_data;
  logic [3:0] tx_valid_ff;
  logic [7:0] tx_data_ff;
  logic [7:0] exp_b[$], got_b[$];
  logic [1:0] exp_p[$], got_p[$];
  logic exp_l[$], got_l[$];
  int failures = 0;
  int n_checks = 0;
  int cycles = 0;
  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;
  record_retransmit_engine #(.NPORT(4), .ID_VALUE(ID_VAL)) i_record_retransmit_engine (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .rec_valid(rec_valid), .rec_data(rec_data),
    .rec_last(rec_last), .rec_ready(rec_ready), .capture_active(capture_active), .tx_valid_ff(tx_valid_ff),
    .tx_data_ff(tx_data_ff), .tx_last_ff(tx_last_ff), .tx_ready(tx_ready));
  record_source i_record_source (.ref_clk(ref_clk), .rstn(rstn), .rec_ready(rec_ready), .rec_valid(rec_valid),
    .rec_data(rec_data), .rec_last(rec_last));
  // Collect every byte handed to a port; a frozen byte counts once
  always @(posedge ref_clk) begin
    if (ce && |tx_valid_ff) begin
      got_b.push_back(tx_data_ff);
      got_p.push_back({tx_valid_ff[3] | tx_valid_ff[2], tx_valid_ff[3] | tx_valid_ff[1]});
      got_l.push_back(tx_last_ff);
    end
  end
  // Cut a hung run short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  task complete_run();
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Answer is sampled mid-cycle, clear of the launching edge
  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rv = reg_rdata_ff;
  endtask
  function automatic logic [7:0] pb(input logic [1:0] p, input int i);
    return 8'(i * 7 + p * 64 + 3);
  endfunction
  // Reflected CRC32, one byte at a time
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? `CRC_POLY : 32'h0);
    return c;
  endfunction
  // Queue one record and the bytes it should produce; opt is strip, crc, drop
  task send(input logic [1:0] p, input logic err, input int nw, input logic [2:0] opt);
    logic [63:0] d;
    logic [31:0] c;
    int n;
    c = `CRC_INIT;
    n = (err && opt[2]) ? 0 : nw * 8 - (opt[0] ? 4 : 0);
    i_record_source.push({24'h0, LINK_TYPE, 7'h0, err, 6'h0, p, 16'(8 + 8 * nw)}, 1'b0);
    for (int w = 0; w < nw; w++) begin
      for (int k = 0; k < 8; k++) d[k*8 +: 8] = pb(p, w * 8 + k);
      i_record_source.push(d, w == nw - 1);
    end
    for (int i = 0; i < n; i++) begin
      exp_b.push_back(pb(p, i));
      exp_p.push_back(p);
      exp_l.push_back(i == n - 1 && !opt[1]);
      c = crc_upd(c, pb(p, i));
    end
    for (int k = 0; k < 4 && opt[1] && n > 0; k++) begin
      exp_b.push_back(~c[k*8 +: 8]);
      exp_p.push_back(p);
      exp_l.push_back(k == 3);
    end
  endtask
  // Wait for the stream to drain, then compare byte by byte
  task settle();
    for (int t = 0; t < 3000 && (got_b.size() < exp_b.size() || i_record_source.q.size() != 0); t++)
      @(posedge ref_clk);
    repeat (12) @(posedge ref_clk);
    check(got_b.size(), exp_b.size());
    for (int i = 0; i < exp_b.size() && i < got_b.size(); i++) begin
      check(got_b[i], exp_b[i]);
      check(got_p[i], exp_p[i]);
      check(got_l[i], exp_l[i]);
    end
    exp_b.delete();
    exp_p.delete();
    exp_l.delete();
    got_b.delete();
    got_p.delete();
    got_l.delete();
  endtask
  // Main sequence; the split is only rewritten with no traffic
  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`REG_TX_MEM);
    check(rv, {16'h0, `TX_MEM_RESET_MB});
    rd(`REG_STATUS);
    check(rv, 32'h0);
    @(posedge ref_clk);
    capture_active <= 1'b1;
    rd(`REG_ID);
    check(rv, ID_VAL);
    rd(4'hf);
    check(rv, 32'h0);
    rd(`REG_STATUS);
    check(rv[7], 1'b1);
    wr(`REG_CTRL, 32'h8);
    settle();
    for (int o = 0; o < 4; o++) begin
      wr(`REG_CTRL, 32'(8 + o));
      send(2'(o), 1'b0, 3, 3'(o));
      if (o == 2) begin
        // Freeze mid-frame; nothing may be lost or repeated
        repeat (20) @(posedge ref_clk);
        ce <= 1'b0;
        repeat (5) @(posedge ref_clk);
        ce <= 1'b1;
      end
      settle();
    end
    wr(`REG_CTRL, 32'hc);
    tx_ready <= 4'hd;
    send(2'h2, 1'b1, 2, 3'h4);
    send(2'h1, 1'b0, 2, 3'h4);
    repeat (60) @(posedge ref_clk);
    check(got_b.size(), 0);
    tx_ready <= 4'hf;
    settle();
    rd(`REG_DROP_CNT);
    check(rv, 32'h1);
    i_record_source.slow = 1'b1;
    wr(`REG_CTRL, 32'h9);
    send(2'h3, 1'b0, 1, 3'h1);
    send(2'h0, 1'b0, 5, 3'h1);
    send(2'h3, 1'b1, 2, 3'h1);
    settle();
    rd(`REG_SENT_CNT);
    check(rv, 32'h8);
    wr(`REG_TX_MEM, 32'h20);
    rd(`REG_TX_MEM);
    check(rv, 32'h20);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`REG_TX_MEM);
    check(rv, {16'h0, `TX_MEM_RESET_MB});
    rd(`REG_SENT_CNT);
    check(rv, 32'h0);
    complete_run();
  end
endmodule // testbench
